// File: shared/ect_pkg.sv
// Constants, register map and mode encodings for the event, count and capture timer.
// Notes on behaviour
// - Event mode counts down on timer pin A rising edges.
// - Event underflow sets pending A; enable A gates.
// - Event mode pin B rise sets pending B.
// - Event mode never drives pin A.
// - Capture mode counter decrements every instruction cycle.
// - Pin triggers copy counter into aux registers.
// - Mode bits pick capture edges per pin.
// - Capture triggers set pending A and B.
// - Capture underflow sets run bit, shares enable A.
// - Run bit starts and stops PWM, event counting.
// - Enable flags gate interrupts from pending flags.
// - PWM reloads alternately, aux A first.
// - PWM underflows set pending A, B alternately.
package ect_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W = 16;

    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_AUX_A = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_AUX_B = 4'h3;

    localparam int unsigned CTRL_EN_B = 0;
    localparam int unsigned CTRL_PEND_B = 1;
    localparam int unsigned CTRL_EN_A = 2;
    localparam int unsigned CTRL_PEND_A = 3;
    localparam int unsigned CTRL_RUN = 4;
    localparam int unsigned CTRL_MODE_LSB = 5;
    localparam int unsigned CTRL_MODE_W = 3;

    localparam logic [2:0] MODE_PWM_TOGGLE = 3'h5;
    localparam logic [2:0] MODE_PWM_QUIET = 3'h4;
    localparam logic [2:0] MODE_EVENT_0 = 3'h0;
    localparam logic [2:0] MODE_EVENT_1 = 3'h1;
    localparam logic [2:0] MODE_CAP_RISE_RISE = 3'h2;
    localparam logic [2:0] MODE_CAP_RISE_FALL = 3'h6;
    localparam logic [2:0] MODE_CAP_FALL_FALL_0 = 3'h3;
    localparam logic [2:0] MODE_CAP_FALL_FALL_1 = 3'h7;

    localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] AUX_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] RDATA_IDLE = 16'h0000;

    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned TC_PERIOD_NS = 1000;
    localparam int unsigned TC_CYCLES = (TC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        ECT_OP_PWM = 4'h1,
        ECT_OP_EVENT = 4'h2,
        ECT_OP_CAPTURE = 4'h4,
        ECT_OP_NONE = 4'h8
    } ect_op_t;
endpackage : ect_pkg

// File: shared/ect_edge_if.sv
// Carrier for a synchronised pin level and its one-cycle edge pulses.
`timescale 1ns/1ps
interface ect_edge_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : ect_edge_if

// File: logic/ect_pin_edge.sv
// Two-stage pin synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps
module ect_pin_edge (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_pin,
    ect_edge_if.src o_edge
);
    logic meta;
    logic sync;
    logic last;

    // The first stage feeds only the second; edges are taken from later stages.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= i_pin;
            sync <= meta;
            last <= sync;
        end
    end

    assign o_edge.level = sync;
    assign o_edge.rise = sync & ~last;
    assign o_edge.fall = ~sync & last;
endmodule : ect_pin_edge

// File: logic/ect_hold_reg.sv
// Holding register loaded by software or by a hardware capture.
`timescale 1ns/1ps
module ect_hold_reg #(
    parameter int unsigned WIDTH = 16,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_wr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic i_capture,
    input wire logic [WIDTH-1:0] i_capture_value,
    output logic [WIDTH-1:0] o_q
);
    // A capture in the same cycle as a software write wins, so no event is lost.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_q <= RESET_VALUE;
        end else if (i_capture) begin
            o_q <= i_capture_value;
        end else if (i_wr) begin
            o_q <= i_wdata;
        end
    end
endmodule : ect_hold_reg

// File: logic/ect_timer.sv
// Sixteen-bit timer with PWM, external event counting and input capture.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module ect_timer (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [ect_pkg::ADDR_W-1:0] i_addr,
    input wire logic [ect_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [ect_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_timer_pin_a,
    input wire logic i_timer_pin_b,
    output logic o_timer_pin_a,
    output logic o_timer_pin_a_oe,
    output logic o_irq_a,
    output logic o_irq_b
);
    import ect_pkg::*;

    localparam int unsigned TC_W = $clog2(TC_CYCLES);
    localparam logic [TC_W-1:0] TC_LAST = TC_W'(TC_CYCLES - 1);

    ect_edge_if pin_a ();
    ect_edge_if pin_b ();

    logic [TC_W-1:0] tc_div;
    logic tc_tick;
    logic [CTRL_MODE_W-1:0] mode;
    logic run_or_underflow_bit;
    logic pending_flag_a;
    logic pending_flag_b;
    logic interrupt_enable_a;
    logic interrupt_enable_b;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] aux_register_a;
    logic [CNT_W-1:0] aux_register_b;
    logic reload_from_b;
    logic pwm_level;
    ect_op_t op;
    logic cap_a_on_fall;
    logic cap_b_on_fall;
    logic count_step;
    logic underflow;
    logic cap_a_trig;
    logic cap_b_trig;
    logic set_pend_a;
    logic set_pend_b;
    logic set_underflow_flag;
    logic wr_ctrl;
    logic wr_count;
    logic wr_aux_a;
    logic wr_aux_b;

    ect_pin_edge u_pin_a (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_pin(i_timer_pin_a),
        .o_edge(pin_a)
    );

    ect_pin_edge u_pin_b (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_pin(i_timer_pin_b),
        .o_edge(pin_b)
    );

    // Instruction cycle clock as a one-cycle enable.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            tc_div <= '0;
        end else if (tc_div == TC_LAST) begin
            tc_div <= '0;
        end else begin
            tc_div <= tc_div + TC_W'(1);
        end
    end

    assign tc_tick = (tc_div == TC_LAST);

    // Mode decode.
    always_comb begin
        op = ECT_OP_NONE;
        case (mode)
            MODE_PWM_TOGGLE, MODE_PWM_QUIET: op = ECT_OP_PWM;
            MODE_EVENT_0, MODE_EVENT_1: op = ECT_OP_EVENT;
            MODE_CAP_RISE_RISE, MODE_CAP_RISE_FALL,
            MODE_CAP_FALL_FALL_0, MODE_CAP_FALL_FALL_1: op = ECT_OP_CAPTURE;
            default: op = ECT_OP_NONE;
        endcase
    end

    assign cap_a_on_fall = (mode == MODE_CAP_FALL_FALL_0) || (mode == MODE_CAP_FALL_FALL_1);
    assign cap_b_on_fall = cap_a_on_fall || (mode == MODE_CAP_RISE_FALL);

    // Register decode.
    always_comb begin
        wr_ctrl = 1'b0;
        wr_count = 1'b0;
        wr_aux_a = 1'b0;
        wr_aux_b = 1'b0;
        if (i_wr && (i_addr == ADDR_CTRL)) begin
            wr_ctrl = 1'b1;
        end else if (i_wr && (i_addr == ADDR_COUNT)) begin
            wr_count = 1'b1;
        end else if (i_wr && (i_addr == ADDR_AUX_A)) begin
            wr_aux_a = 1'b1;
        end else if (i_wr && (i_addr == ADDR_AUX_B)) begin
            wr_aux_b = 1'b1;
        end
    end

    // Counting sources per mode.
    always_comb begin
        count_step = 1'b0;
        case (op)
            ECT_OP_PWM: count_step = run_or_underflow_bit & tc_tick;
            ECT_OP_EVENT: count_step = run_or_underflow_bit & pin_a.rise;
            ECT_OP_CAPTURE: count_step = tc_tick;
            default: count_step = 1'b0;
        endcase
    end

    assign underflow = count_step && (count == COUNT_ZERO);
    assign cap_a_trig = (op == ECT_OP_CAPTURE) && (cap_a_on_fall ? pin_a.fall : pin_a.rise);
    assign cap_b_trig = (op == ECT_OP_CAPTURE) && (cap_b_on_fall ? pin_b.fall : pin_b.rise);

    // Pending sources per mode.
    always_comb begin
        set_pend_a = 1'b0;
        set_pend_b = 1'b0;
        set_underflow_flag = 1'b0;
        case (op)
            ECT_OP_PWM: begin
                set_pend_a = underflow & ~reload_from_b;
                set_pend_b = underflow & reload_from_b;
            end
            ECT_OP_EVENT: begin
                set_pend_a = underflow;
                set_pend_b = pin_b.rise;
            end
            ECT_OP_CAPTURE: begin
                set_pend_a = cap_a_trig;
                set_pend_b = cap_b_trig;
                set_underflow_flag = underflow;
            end
            default: begin
                set_pend_a = 1'b0;
                set_pend_b = 1'b0;
            end
        endcase
    end

    // Next counter value; a software load takes priority over a step.
    always_comb begin
        next_count = count;
        if (wr_count) begin
            next_count = i_wdata[CNT_W-1:0];
        end else if (underflow && (op == ECT_OP_PWM)) begin
            next_count = reload_from_b ? aux_register_b : aux_register_a;
        end else if (underflow && (op == ECT_OP_EVENT)) begin
            next_count = aux_register_a;
        end else if (count_step) begin
            next_count = count - CNT_W'(1);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            count <= COUNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    // Stopping or leaving PWM rearms the sequence so the first reload is from A.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            reload_from_b <= 1'b0;
        end else if ((op != ECT_OP_PWM) || !run_or_underflow_bit) begin
            reload_from_b <= 1'b0;
        end else if (underflow) begin
            reload_from_b <= ~reload_from_b;
        end
    end

    // Control register; hardware sets win over a software clear in the same cycle.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            mode <= MODE_EVENT_0;
            interrupt_enable_a <= 1'b0;
            interrupt_enable_b <= 1'b0;
        end else if (wr_ctrl) begin
            mode <= i_wdata[CTRL_MODE_LSB +: CTRL_MODE_W];
            interrupt_enable_a <= i_wdata[CTRL_EN_A];
            interrupt_enable_b <= i_wdata[CTRL_EN_B];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            run_or_underflow_bit <= 1'b0;
        end else if (wr_ctrl) begin
            run_or_underflow_bit <= i_wdata[CTRL_RUN] | set_underflow_flag;
        end else if (set_underflow_flag) begin
            run_or_underflow_bit <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pending_flag_a <= 1'b0;
            pending_flag_b <= 1'b0;
        end else if (wr_ctrl) begin
            pending_flag_a <= i_wdata[CTRL_PEND_A] | set_pend_a;
            pending_flag_b <= i_wdata[CTRL_PEND_B] | set_pend_b;
        end else begin
            pending_flag_a <= pending_flag_a | set_pend_a;
            pending_flag_b <= pending_flag_b | set_pend_b;
        end
    end

    ect_hold_reg #(
        .WIDTH(CNT_W),
        .RESET_VALUE(AUX_RESET)
    ) u_aux_a (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_wr(wr_aux_a),
        .i_wdata(i_wdata[CNT_W-1:0]),
        .i_capture(cap_a_trig),
        .i_capture_value(count),
        .o_q(aux_register_a)
    );

    ect_hold_reg #(
        .WIDTH(CNT_W),
        .RESET_VALUE(AUX_RESET)
    ) u_aux_b (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_wr(wr_aux_b),
        .i_wdata(i_wdata[CNT_W-1:0]),
        .i_capture(cap_b_trig),
        .i_capture_value(count),
        .o_q(aux_register_b)
    );

    // Pin A drives only in toggling PWM; in event and capture it is an input.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            pwm_level <= 1'b0;
        end else if ((mode == MODE_PWM_TOGGLE) && underflow) begin
            pwm_level <= ~pwm_level;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_timer_pin_a <= 1'b0;
            o_timer_pin_a_oe <= 1'b0;
        end else begin
            o_timer_pin_a <= pwm_level;
            o_timer_pin_a_oe <= (mode == MODE_PWM_TOGGLE);
        end
    end

    // The capture underflow shares request line A with the pin A capture.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_irq_a <= 1'b0;
            o_irq_b <= 1'b0;
        end else begin
            o_irq_a <= interrupt_enable_a &
                (pending_flag_a | ((op == ECT_OP_CAPTURE) & run_or_underflow_bit));
            o_irq_b <= interrupt_enable_b & pending_flag_b;
        end
    end

    // Read data stand only in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_rdata <= RDATA_IDLE;
        end else if (i_rd && (i_addr == ADDR_CTRL)) begin
            o_rdata <= RDATA_IDLE;
            o_rdata[CTRL_MODE_LSB +: CTRL_MODE_W] <= mode;
            o_rdata[CTRL_RUN] <= run_or_underflow_bit;
            o_rdata[CTRL_PEND_A] <= pending_flag_a;
            o_rdata[CTRL_EN_A] <= interrupt_enable_a;
            o_rdata[CTRL_PEND_B] <= pending_flag_b;
            o_rdata[CTRL_EN_B] <= interrupt_enable_b;
        end else if (i_rd && (i_addr == ADDR_COUNT)) begin
            o_rdata <= count;
        end else if (i_rd && (i_addr == ADDR_AUX_A)) begin
            o_rdata <= aux_register_a;
        end else if (i_rd && (i_addr == ADDR_AUX_B)) begin
            o_rdata <= aux_register_b;
        end else begin
            o_rdata <= RDATA_IDLE;
        end
    end
endmodule : ect_timer

// File: dv/ect_timer_checker.sv
// Concurrent checks on the timer's register port, pin drive and interrupt lines.
`timescale 1ns/1ps
module ect_timer_checker (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [ect_pkg::ADDR_W-1:0] i_addr,
    input wire logic [ect_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [ect_pkg::DATA_W-1:0] o_rdata,
    input wire logic o_timer_pin_a_oe,
    input wire logic o_irq_a,
    input wire logic o_irq_b
);
    import ect_pkg::*;
    logic [2:0] mode_q;
    logic en_a_q;
    logic en_b_q;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    // Mode and enables are written only by software, so this shadow is exact.
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            mode_q <= 3'h0;
            en_a_q <= 1'b0;
            en_b_q <= 1'b0;
        end else if (i_wr && i_addr == ADDR_CTRL) begin
            mode_q <= i_wdata[CTRL_MODE_LSB +: 3];
            en_a_q <= i_wdata[CTRL_EN_A];
            en_b_q <= i_wdata[CTRL_EN_B];
        end
    end
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == RDATA_IDLE)
        else $error("read data not idle");
    unmapped_read_a: assert property ($past(i_rd) && $past(i_addr) > ADDR_AUX_B
        |-> o_rdata == RDATA_IDLE) else $error("unmapped read not zero");
    ctrl_readback_a: assert property (
        $past(i_rd) && $past(i_addr) == ADDR_CTRL |-> o_rdata[7:5] == $past(mode_q)
        && o_rdata[2] == $past(en_a_q) && o_rdata[0] == $past(en_b_q)
        && o_rdata[15:8] == 8'h00) else $error("control readback wrong");
    pin_drive_a: assert property (mode_q == $past(mode_q)
        |-> o_timer_pin_a_oe == (mode_q == MODE_PWM_TOGGLE)) else $error("pin drive wrong");
    irq_a_gate_a: assert property (!en_a_q && !$past(en_a_q) |-> !o_irq_a)
        else $error("irq a while disabled");
    irq_b_gate_a: assert property (!en_b_q && !$past(en_b_q) |-> !o_irq_b)
        else $error("irq b while disabled");
    irq_a_hold_a: assert property ($fell(o_irq_a) |-> $past(i_wr) || $past(i_wr, 2))
        else $error("irq a dropped without write");
    irq_b_hold_a: assert property ($fell(o_irq_b) |-> $past(i_wr) || $past(i_wr, 2))
        else $error("irq b dropped without write");
endmodule : ect_timer_checker

bind ect_timer ect_timer_checker u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_timer_pin_a_oe(o_timer_pin_a_oe), .o_irq_a(o_irq_a), .o_irq_b(o_irq_b));

// File: dv/ect_pin_src.sv
// Pulse source standing in for the external event and capture pins.
`timescale 1ns/1ps
module ect_pin_src (
    input wire logic i_mclk,
    output logic o_pin_a,
    output logic o_pin_b
);
    initial begin
        o_pin_a = 1'b0;
        o_pin_b = 1'b0;
    end
    // Each level is held six clocks so the synchroniser never misses an edge.
    task automatic drive(input logic sel_b, input logic lvl);
        @(posedge i_mclk);
        if (sel_b) begin
            o_pin_b <= lvl;
        end else begin
            o_pin_a <= lvl;
        end
        repeat (6) @(posedge i_mclk);
    endtask : drive
endmodule : ect_pin_src

// File: dv/tb_top.sv
// Self-checking bench for the event, count and capture timer.
`timescale 1ns/1ps
module tb_top;
    import ect_pkg::*;
    logic i_mclk;
    logic i_rst_n;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [DATA_W-1:0] o_rdata;
    logic pin_a;
    logic pin_b;
    logic o_timer_pin_a;
    logic o_timer_pin_a_oe;
    logic o_irq_a;
    logic o_irq_b;
    logic [DATA_W-1:0] rd_val;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;

    ect_timer u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer_pin_a(pin_a),
        .i_timer_pin_b(pin_b), .o_timer_pin_a(o_timer_pin_a),
        .o_timer_pin_a_oe(o_timer_pin_a_oe), .o_irq_a(o_irq_a), .o_irq_b(o_irq_b));
    ect_pin_src u_src (.i_mclk(i_mclk), .o_pin_a(pin_a), .o_pin_b(pin_b));

    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            failures = failures + 1;
            final_report();
        end
    end

    task automatic final_report();
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask : rd

    function automatic logic [DATA_W-1:0] ctl(logic [2:0] m, logic run, logic ea, logic eb);
        return 16'(m) << CTRL_MODE_LSB | 16'(run) << CTRL_RUN | 16'(ea) << CTRL_EN_A
            | 16'(eb) << CTRL_EN_B;
    endfunction : ctl

    task automatic t_modes();
        wr(ADDR_COUNT, 16'h1234);
        for (int m = 0; m < 8; m++) begin
            wr(ADDR_CTRL, ctl(3'(m), 1'b0, 1'b1, 1'b1));
            rd(ADDR_CTRL);
            chk(rd_val, ctl(3'(m), 1'b0, 1'b1, 1'b1));
            chk(16'(o_timer_pin_a_oe), 16'(m == 5));
        end
    endtask : t_modes

    task automatic t_event();
        // Leave capture mode first, or a tick could step the count just loaded.
        wr(ADDR_CTRL, ctl(MODE_EVENT_1, 1'b0, 1'b1, 1'b1));
        wr(ADDR_AUX_A, 16'h0003);
        wr(ADDR_COUNT, 16'h0001);
        u_src.drive(1'b0, 1'b1);
        u_src.drive(1'b0, 1'b0);
        rd(ADDR_COUNT);
        chk(rd_val, 16'h0001);
        wr(ADDR_CTRL, ctl(MODE_EVENT_0, 1'b1, 1'b1, 1'b1));
        u_src.drive(1'b0, 1'b1);
        u_src.drive(1'b0, 1'b0);
        rd(ADDR_COUNT);
        chk(rd_val, 16'h0000);
        u_src.drive(1'b0, 1'b1);
        rd(ADDR_COUNT);
        chk(rd_val, 16'h0003);
        rd(ADDR_CTRL);
        chk(rd_val, ctl(MODE_EVENT_0, 1'b1, 1'b1, 1'b1) | 16'h0008);
        chk(16'({o_irq_a, o_irq_b}), 16'h0002);
        u_src.drive(1'b1, 1'b1);
        chk(16'({o_irq_a, o_irq_b}), 16'h0003);
        u_src.drive(1'b0, 1'b0);
        u_src.drive(1'b1, 1'b0);
    endtask : t_event

    task automatic t_cap_run();
        logic [DATA_W-1:0] c0;
        wr(ADDR_COUNT, 16'h0001);
        wr(ADDR_CTRL, ctl(MODE_CAP_RISE_RISE, 1'b0, 1'b1, 1'b1));
        repeat (60) @(posedge i_mclk);
        rd(ADDR_CTRL);
        chk(rd_val & 16'h0018, 16'h0010);
        chk(16'(o_irq_a), 16'h0001);
        wr(ADDR_CTRL, ctl(MODE_CAP_RISE_RISE, 1'b0, 1'b1, 1'b1));
        rd(ADDR_COUNT);
        c0 = rd_val;
        repeat (38) @(posedge i_mclk);
        rd(ADDR_COUNT);
        chk(c0 - rd_val, 16'h0002);
    endtask : t_cap_run

    task automatic cap(input logic [2:0] m, input logic sb, input logic lvl, input logic hit);
        logic [DATA_W-1:0] c0;
        logic [DATA_W-1:0] aux;
        wr(ADDR_CTRL, ctl(m, 1'b0, 1'b1, 1'b1));
        rd(ADDR_COUNT);
        c0 = rd_val;
        u_src.drive(sb, lvl);
        rd(sb ? ADDR_AUX_B : ADDR_AUX_A);
        aux = rd_val;
        rd(ADDR_COUNT);
        if (hit) begin
            chk(16'(aux <= c0 && aux >= rd_val), 16'h0001);
        end
        rd(ADDR_CTRL);
        chk(16'(rd_val[sb ? CTRL_PEND_B : CTRL_PEND_A]), 16'(hit));
        chk(16'(sb ? o_irq_b : o_irq_a), 16'(hit));
    endtask : cap

    task automatic wait_pend();
        for (int i = 0; i < 200; i++) begin
            rd(ADDR_CTRL);
            if (rd_val[CTRL_PEND_A] | rd_val[CTRL_PEND_B]) begin
                break;
            end
        end
    endtask : wait_pend

    task automatic t_pwm();
        logic p0;
        logic [DATA_W-1:0] c1;
        // Stop in PWM first, so a capture tick cannot underflow the zero load.
        wr(ADDR_CTRL, ctl(MODE_PWM_TOGGLE, 1'b0, 1'b0, 1'b0));
        wr(ADDR_AUX_A, 16'h0002);
        wr(ADDR_AUX_B, 16'h0004);
        wr(ADDR_COUNT, 16'h0000);
        wr(ADDR_CTRL, ctl(MODE_PWM_TOGGLE, 1'b1, 1'b0, 1'b0));
        wait_pend();
        chk(rd_val, ctl(MODE_PWM_TOGGLE, 1'b1, 1'b0, 1'b0) | 16'h0008);
        p0 = o_timer_pin_a;
        rd(ADDR_COUNT);
        chk(rd_val, 16'h0002);
        wr(ADDR_CTRL, ctl(MODE_PWM_TOGGLE, 1'b1, 1'b0, 1'b0));
        wait_pend();
        chk(rd_val, ctl(MODE_PWM_TOGGLE, 1'b1, 1'b0, 1'b0) | 16'h0002);
        rd(ADDR_COUNT);
        chk(rd_val, 16'h0004);
        chk(16'({o_timer_pin_a_oe, o_timer_pin_a == p0}), 16'h0002);
        wr(ADDR_CTRL, ctl(MODE_PWM_TOGGLE, 1'b0, 1'b0, 1'b0));
        rd(ADDR_COUNT);
        c1 = rd_val;
        repeat (60) @(posedge i_mclk);
        rd(ADDR_COUNT);
        chk(rd_val, c1);
    endtask : t_pwm

    initial begin
        i_rst_n = 1'b0;
        i_addr = '0;
        i_wdata = '0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        repeat (6) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        for (int a = 0; a < 5; a++) begin
            rd(a == 4 ? 4'hc : 4'(a));
            chk(rd_val, 16'h0000);
        end
        t_modes();
        t_event();
        t_cap_run();
        cap(MODE_CAP_RISE_RISE, 1'b0, 1'b1, 1'b1);
        cap(MODE_CAP_RISE_RISE, 1'b1, 1'b1, 1'b1);
        cap(MODE_CAP_RISE_FALL, 1'b0, 1'b0, 1'b0);
        cap(MODE_CAP_RISE_FALL, 1'b1, 1'b0, 1'b1);
        cap(MODE_CAP_FALL_FALL_0, 1'b0, 1'b1, 1'b0);
        cap(MODE_CAP_FALL_FALL_1, 1'b0, 1'b0, 1'b1);
        t_pwm();
        final_report();
    end
endmodule : tb_top
